// [rccm_pkg.sv]
package rccm_pkg;
	// Coil numbers as printed (one-based), held as indices
	localparam logic [15:0] SC_FIRST_COIL = 16'h0021;
	localparam logic [15:0] SC_LAST_COIL = 16'h0036;
	localparam logic [15:0] RSV_A_FIRST = 16'h0037;
	localparam logic [15:0] RSV_A_LAST = 16'h0040;
	localparam logic [15:0] AR_COIL = 16'h0041;
	localparam logic [15:0] PROT_COIL = 16'h0042;
	localparam logic [15:0] GRP_A_COIL = 16'h0043;
	localparam logic [15:0] GRP_D_COIL = 16'h0046;
	localparam logic [15:0] REMOTE_COIL = 16'h0047;
	localparam logic [15:0] RSV_B_FIRST = 16'h0048;
	// Own registers: mode config and status, at word indices
	localparam logic [15:0] MODE_CFG_COIL = 16'h0100;
	localparam logic [15:0] STATUS_COIL = 16'h0101;
	localparam int NUM_SC = 22;
	// Default mode per channel: 1 = pulse (bit n-1 is channel n)
	localparam logic [21:0] MODE_RESET = 22'h0fe1ff;
	// Channels with checkback: 1 to 4
	localparam logic [21:0] CHECKBACK_MASK = 22'h00000f;
	// Continuous channels that keep state across reset: 12, 13
	localparam logic [21:0] RETAIN_MASK = 22'h001800;
	localparam logic [1:0] GRP_RESET = 2'h0;
	localparam logic [7:0] PARAM_GROUP_SRC = 8'h00;
	// Group-change source value meaning the protocol
	localparam logic [1:0] GRP_SRC_PROTOCOL = 2'h1;
	localparam int CLOCK_MHZ = 125;
	localparam int UNLOCK_TIMEOUT_MIN = 5;
	localparam longint UNLOCK_TIMEOUT_CYC =
		longint'(UNLOCK_TIMEOUT_MIN) * 60 * CLOCK_MHZ * 1000000;
	localparam int PULSE_CYC_DEFAULT = 125;
	localparam logic [31:0] ERR_REJECT = 32'hffff_ffff;

	typedef struct packed {
		logic read;
		logic write;
		logic [15:0] address;
		logic [31:0] writedata;
	} rccm_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic [1:0] response;
		logic waitrequest;
	} rccm_rsp_t;
endpackage

// [rccm_pulse.sv]
`timescale 1ns/10ps
module rccm_pulse #(
	parameter int WIDTH = 24
) (
	// Clock
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_enable,
	// Control
	input wire logic i_fire,
	input wire logic [WIDTH-1:0] i_length,
	// Output
	output logic o_active
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic active;
	} rccm_pulse_t;
	rccm_pulse_t st;
	rccm_pulse_t next_st;
	initial begin
		if (WIDTH < 2) $error("rccm_pulse width too small");
	end
	always_comb begin
		next_st = st;
		if (i_fire) begin
			next_st.count = i_length;
			next_st.active = 1'b1;
		end else if (st.active) begin
			next_st.count = st.count - 1'b1;
			if (st.count <= 1) next_st.active = 1'b0;
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) st <= '0;
		else if (i_enable) st <= next_st;
	end
	assign o_active = st.active;
endmodule // rccm_pulse

// [rccm_sync.sv]
`timescale 1ns/10ps
module rccm_sync #(
	parameter int WIDTH = 4
) (
	// Clock
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_enable,
	// Data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} rccm_sync_t;
	rccm_sync_t st;
	rccm_sync_t next_st;
	always_comb begin
		next_st.meta = i_async;
		next_st.stable = st.meta;
	end
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) st <= '0;
		else if (i_enable) st <= next_st;
	end
	assign o_sync = st.stable;
endmodule // rccm_sync

// [rccm_top.sv]
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
// Operation
// - Coils 33..54 map one-to-one onto channels 1..22.
// - Channels 1..4 default to pulse outputs with checkback.
// - Channels 5..9 and 14..20 default to pulse without checkback.
// - Channels 10, 11, 21, 22 continuous; cleared by reset.
// - Channels 12, 13 continuous; state kept across reset.
// - Reserved coils read zero; writes to them rejected.
// - Pulse or continuous mode is per-channel configurable.
// - Writing OFF to a pulse channel is rejected.
// - Pulse-with-checkback command rejected while checkback is ON.
// - Autoreclose coil: write 0 off, 1 on; reads status.
// - Protection coil: write 0 off, 1 on; reads any-active.
// - Group coils accept only 1; read 1 when group active.
// - Remote mode coil: 0 locked, 1 unlocked; reads mode.
// - Unlocked permits one command, then relocks by itself; commands are accepted while locked too.
// - No command within 5 minutes after unlock relocks.
// - Plausibility test still applies to unlocked commands.
// - New group replaces old; writing 0 is refused.
// - Group change only when source parameter selects protocol.
module rccm_top
	import rccm_pkg::*;
#(
	parameter longint UNLOCK_CYC = UNLOCK_TIMEOUT_CYC,
	parameter int PULSE_CYC = PULSE_CYC_DEFAULT
) (
	// Clock, reset, enable
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_enable,
	// Avalon-MM slave
	input wire rccm_pkg::rccm_req_t i_avs,
	output rccm_pkg::rccm_rsp_t o_avs,
	// Field pins
	input wire logic [3:0] i_checkback,
	input wire logic i_plausible,
	input wire logic [1:0] i_group_source,
	input wire logic i_prot_any_active,
	// Outputs
	output logic [21:0] o_channel,
	output logic o_autoreclose_on_status,
	output logic o_protection_enable,
	output logic [1:0] o_group,
	output logic o_remote_control_mode_status
);
	import rccm_pkg::*;

	localparam int PW = 24;
	localparam int UW = 36;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_DECODE = 2'b01,
		PH_ANSWER = 2'b10
	} rccm_phase_t;

	typedef struct packed {
		logic [21:0] mode;
		logic [21:0] level;
		logic [21:0] retained;
		logic ar_on;
		logic prot_on;
		logic [1:0] group;
		logic unlocked;
		logic [UW-1:0] unlock_cnt;
		rccm_phase_t phase;
		logic [31:0] rdata;
		logic [1:0] resp;
		logic waitreq;
		logic [21:0] channel_q;
	} rccm_state_t;

	rccm_state_t st;
	rccm_state_t next_st;
	logic [21:0] fire;
	logic [21:0] pulse_act;
	logic [3:0] cb_sync;
	logic [3:0] misc_sync;
	logic [21:0] cb_ext;
	logic [15:0] idx;
	logic [4:0] ch;
	logic bit_val;
	logic is_sc;
	logic is_grp;

	initial begin
		if (PULSE_CYC < 1 || PULSE_CYC >= (1 << PW)) $error("rccm_top pulse length out of range");
		if (UNLOCK_CYC < 1 || UNLOCK_CYC >= (longint'(1) << UW)) $error("rccm_top unlock out of range");
	end

	// Field pins come from outside the clock domain
	rccm_sync #(.WIDTH(4)) u_cb_sync (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_enable(i_enable),
		.i_async(i_checkback),
		.o_sync(cb_sync)
	);
	rccm_sync #(.WIDTH(4)) u_misc_sync (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_enable(i_enable),
		.i_async({i_plausible, i_group_source, i_prot_any_active}),
		.o_sync(misc_sync)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_SC; g++) begin : g_pulse
			rccm_pulse #(.WIDTH(PW)) u_pulse (
				.i_clock(i_clock),
				.i_sys_rst(i_sys_rst),
				.i_enable(i_enable),
				.i_fire(fire[g]),
				.i_length(PW'(PULSE_CYC)),
				.o_active(pulse_act[g])
			);
		end
	endgenerate

	assign cb_ext = {18'h00000, cb_sync} & CHECKBACK_MASK;
	// Bus address is the coil number minus one
	assign idx = 16'(i_avs.address + 16'h0001);
	assign ch = 5'(idx - SC_FIRST_COIL);
	assign bit_val = i_avs.writedata[0];
	assign is_sc = (idx >= SC_FIRST_COIL) && (idx <= SC_LAST_COIL);
	assign is_grp = (idx >= GRP_A_COIL) && (idx <= GRP_D_COIL);

	always_comb begin
		next_st = st;
		fire = '0;
		next_st.waitreq = 1'b1;
		next_st.resp = 2'h0;
		// Continuous channels keep their level; pulses come from timers
		next_st.channel_q = (st.level & ~st.mode) | (pulse_act & st.mode);
		if (st.unlocked) begin
			if (st.unlock_cnt == '0) next_st.unlocked = 1'b0;
			else next_st.unlock_cnt = st.unlock_cnt - 1'b1;
		end
		// Two-phase access: decode, then release waitrequest for one cycle
		case (st.phase)
			PH_IDLE: begin
				if (i_avs.read || i_avs.write) next_st.phase = PH_DECODE;
			end
			PH_DECODE: begin
				next_st.phase = PH_ANSWER;
				next_st.waitreq = 1'b0;
				next_st.rdata = '0;
				if (i_avs.read) begin
					if (is_sc) next_st.rdata[0] = next_st.channel_q[ch] | cb_ext[ch];
					else if (idx == AR_COIL) next_st.rdata[0] = st.ar_on;
					else if (idx == PROT_COIL) next_st.rdata[0] = misc_sync[0];
					else if (is_grp) next_st.rdata[0] = (st.group == 2'(idx - GRP_A_COIL));
					else if (idx == REMOTE_COIL) next_st.rdata[0] = st.unlocked;
					else if (i_avs.address == MODE_CFG_COIL) next_st.rdata = {10'h000, st.mode};
					else if (i_avs.address == STATUS_COIL) next_st.rdata = {10'h000, st.channel_q};
					else next_st.resp = 2'h2;
				end else begin
					if (is_sc) begin
						// Commands need the plausibility check even when unlocked
						if (!misc_sync[3]) next_st.resp = 2'h2;
						else if (st.mode[ch] && !bit_val) next_st.resp = 2'h2;
						else if (st.mode[ch] && cb_ext[ch]) next_st.resp = 2'h2;
						else if (st.mode[ch]) fire[ch] = 1'b1;
						else next_st.level[ch] = bit_val;
						if (next_st.resp == 2'h0 && st.unlocked) next_st.unlocked = 1'b0;
					end else if (idx == AR_COIL) begin
						next_st.ar_on = bit_val;
					end else if (idx == PROT_COIL) begin
						next_st.prot_on = bit_val;
					end else if (is_grp) begin
						if (!bit_val || misc_sync[2:1] != GRP_SRC_PROTOCOL) next_st.resp = 2'h2;
						else next_st.group = 2'(idx - GRP_A_COIL);
					end else if (idx == REMOTE_COIL) begin
						next_st.unlocked = bit_val;
						next_st.unlock_cnt = UW'(UNLOCK_CYC);
					end else if (i_avs.address == MODE_CFG_COIL) begin
						next_st.mode = i_avs.writedata[21:0];
					end else begin
						next_st.resp = 2'h2;
					end
				end
			end
			PH_ANSWER: next_st.phase = PH_IDLE;
			default: next_st.phase = PH_IDLE;
		endcase
		next_st.retained = next_st.level & RETAIN_MASK;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			st <= '0;
			st.mode <= MODE_RESET;
			st.waitreq <= 1'b1;
			st.group <= GRP_RESET;
			// Retained continuous channels survive a device reset
			st.level <= st.retained;
			st.retained <= st.retained;
		end else if (i_enable) begin
			st <= next_st;
		end
	end

	assign o_avs.readdata = st.rdata;
	assign o_avs.response = st.resp;
	assign o_avs.waitrequest = st.waitreq;
	assign o_channel = st.channel_q;
	assign o_autoreclose_on_status = st.ar_on;
	assign o_protection_enable = st.prot_on;
	assign o_group = st.group;
	assign o_remote_control_mode_status = st.unlocked;
endmodule // rccm_top

// [rccm_master.sv]
`timescale 1ns/10ps
module rccm_master
	import rccm_pkg::*;
(
	// Bus
	input wire logic i_clock,
	input wire rccm_pkg::rccm_rsp_t i_rsp,
	output rccm_pkg::rccm_req_t o_req
);
	initial o_req = '0;
	// Released lines carry inverted values so stale data cannot pass
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		@(posedge i_clock);
		o_req <= {!w, w, a, d};
		do @(posedge i_clock); while (i_rsp.waitrequest !== 1'b0);
		q = i_rsp.readdata;
		r = i_rsp.response;
		o_req <= {2'h0, ~a, ~d};
	endtask
endmodule // rccm_master

// [rccm_top_assertions.sv]
`timescale 1ns/10ps
module rccm_top_assertions
	import rccm_pkg::*;
(
	// Bus
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire rccm_pkg::rccm_req_t i_avs,
	input wire rccm_pkg::rccm_rsp_t o_avs,
	// Levels
	input wire logic o_autoreclose_on_status,
	input wire logic o_protection_enable,
	input wire logic [1:0] o_group,
	input wire logic o_remote_control_mode_status
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	wire [15:0] a = i_avs.address;
	wire rsv = (a >= RSV_A_FIRST - 1 && a <= RSV_A_LAST - 1) ||
		(a >= RSV_B_FIRST - 1 && a < MODE_CFG_COIL);
	wire grp = a >= GRP_A_COIL - 1 && a <= GRP_D_COIL - 1;
	wire [1:0] gsel = 2'(a - GRP_A_COIL + 1);
	sequence s_req; $rose(i_avs.read | i_avs.write); endsequence
	sequence s_wr(c); $rose(i_avs.write) && a == c - 1 ##2 o_avs.response == 2'h0; endsequence
	property p_answer; s_req |-> o_avs.waitrequest [*2] ##1 !o_avs.waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("answer latency wrong");
	property p_single; !o_avs.waitrequest |=> o_avs.waitrequest; endproperty
	a_single: assert property (p_single) else $error("answer held too long");
	property p_rsv;
		s_req ##0 rsv |-> ##2 o_avs.response == 2'h2 && (i_avs.write || o_avs.readdata == 0);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved coil not refused");
	property p_ar; s_wr(AR_COIL) |-> ##2 o_autoreclose_on_status == $past(i_avs.writedata[0], 2);
	endproperty
	a_ar: assert property (p_ar) else $error("autoreclose level wrong");
	property p_prot; s_wr(PROT_COIL) |-> ##2 o_protection_enable == $past(i_avs.writedata[0], 2);
	endproperty
	a_prot: assert property (p_prot) else $error("protection level wrong");
	property p_remote;
		s_wr(REMOTE_COIL) |-> ##2 o_remote_control_mode_status == $past(i_avs.writedata[0], 2);
	endproperty
	a_remote: assert property (p_remote) else $error("remote mode wrong");
	property p_grp_sel;
		$rose(i_avs.write) && i_avs.writedata[0] && grp ##2 o_avs.response == 2'h0 |->
			##2 o_group == $past(gsel, 2);
	endproperty
	a_grp_sel: assert property (p_grp_sel) else $error("group not selected");
	property p_grp_zero; $rose(i_avs.write) && grp && !i_avs.writedata[0] |->
		##2 o_avs.response == 2'h2 ##2 o_group == $past(o_group, 4);
	endproperty
	a_grp_zero: assert property (p_grp_zero) else $error("group zero not refused");
endmodule // rccm_top_assertions

bind rccm_top rccm_top_assertions u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_avs(i_avs), .o_avs(o_avs), .o_autoreclose_on_status(o_autoreclose_on_status),
	.o_protection_enable(o_protection_enable), .o_group(o_group),
	.o_remote_control_mode_status(o_remote_control_mode_status));

// [rccm_top_tb.sv]
`timescale 1ns/10ps
module rccm_top_tb;
	import rccm_pkg::*;
	localparam int PW = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] cb = 4'h0;
	logic pl = 1'b1;
	logic [1:0] gs = 2'h1;
	logic pa = 1'b0;
	rccm_req_t req;
	rccm_rsp_t rsp;
	logic [21:0] ch;
	logic [1:0] grp;
	logic ar, pe, rm;
	logic [31:0] q;
	logic [1:0] r;
	int fail_count = 0, checked = 0, cyc = 0, n;
	int cl[$] = '{55, 64, 72, 129, 33, 36, 37, 46, 52};
	always #4 clk = ~clk;
	rccm_top #(.UNLOCK_CYC(1000), .PULSE_CYC(PW)) dut (.i_clock(clk), .i_sys_rst(rst),
		.i_enable(1'b1), .i_avs(req), .o_avs(rsp), .i_checkback(cb), .i_plausible(pl),
		.i_group_source(gs), .i_prot_any_active(pa), .o_channel(ch),
		.o_autoreclose_on_status(ar), .o_protection_enable(pe), .o_group(grp),
		.o_remote_control_mode_status(rm));
	rccm_master m (.i_clock(clk), .i_rsp(rsp), .o_req(req));
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic acc(input logic w, input int c, input logic [31:0] d, input logic [1:0] e);
		m.xfer(w, 16'(c - 1), d, q, r);
		chk(r, e, "response");
	endtask
	task automatic reset();
		@(posedge clk);
		rst <= 1'b1;
		tick(5);
		rst <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(31));
		reset();
		for (int i = 0; i < 4; i++) begin
			pa <= 1'($urandom);
			acc(1'b1, AR_COIL, !i[0], 2'h0);
			acc(1'b1, PROT_COIL, !i[0], 2'h0);
			acc(1'b0, PROT_COIL, 32'h0, 2'h0);
			chk(q, pa, "protection status");
			chk({ar, pe}, {2{!i[0]}}, "levels");
		end
		for (int g = 3; g >= 0; g--) begin
			acc(1'b1, GRP_A_COIL + g, 32'h1, 2'h0);
			acc(1'b0, GRP_A_COIL + (g ^ 1), 32'h0, 2'h0);
			chk(q, 32'h0, "group status");
			chk(grp, g, "group");
		end
		acc(1'b1, GRP_A_COIL + 2, 32'h0, 2'h2);
		gs <= 2'($urandom_range(3, 2));
		tick(4);
		acc(1'b1, GRP_A_COIL + 1, 32'h1, 2'h2);
		chk(grp, 2'h0, "group");
		for (int j = 0; j < 4; j++) begin
			acc(1'b0, cl[j], 32'h0, 2'h2);
			chk(q, 32'h0, "reserved");
			acc(1'b1, cl[j], 32'h1, 2'h2);
		end
		acc(1'b1, 37, 32'h0, 2'h2);
		cb <= 4'h1;
		tick(4);
		acc(1'b1, 33, 32'h1, 2'h2);
		cb <= 4'h0;
		tick(4);
		for (int j = 4; j < 9; j++) begin
			n = 0;
			acc(1'b1, cl[j], 32'h1, 2'h0);
			repeat (PW + 8) begin
				@(posedge clk);
				n += ch[cl[j] - 33];
			end
			chk(n, PW, "pulse width");
		end
		pl <= 1'b0;
		tick(4);
		acc(1'b1, 42, 32'h1, 2'h2);
		pl <= 1'b1;
		tick(4);
		foreach (cl[j])
			acc(1'b1, j < 4 ? 42 + 2 * j : 54, 32'h1, 2'h0);
		tick(2);
		chk(ch, 22'h200a00, "continuous");
		reset();
		tick(2);
		chk(ch, 22'h000800, "after reset");
		acc(1'b1, 257, 32'(MODE_RESET & ~22'h10), 2'h0);
		acc(1'b1, 37, 32'h0, 2'h0);
		acc(1'b1, 37, 32'h1, 2'h0);
		tick(PW + 8);
		chk(ch[4], 1'b1, "mode");
		acc(1'b1, REMOTE_COIL, 32'h1, 2'h0);
		acc(1'b0, REMOTE_COIL, 32'h0, 2'h0);
		chk(q, 32'h1, "remote");
		acc(1'b1, 43, 32'h1, 2'h0);
		tick(2);
		chk(rm, 1'b0, "relock");
		acc(1'b1, REMOTE_COIL, 32'h1, 2'h0);
		tick(960);
		chk(rm, 1'b1, "unlocked");
		tick(60);
		chk(rm, 1'b0, "timeout");
		report_and_stop();
	end
endmodule // rccm_top_tb
